// ### verilog/pfrc_regs.svh
// register indices, field positions, reset values and divide factors
`ifndef PFRC_REGS_SVH
`define PFRC_REGS_SVH

// register indices; byte address is four times the index
`define PFRC_IDX_PULLDOWN 8'h4b
`define PFRC_IDX_DRIVE_A 8'h4c
`define PFRC_IDX_DRIVE_B 8'h4d
`define PFRC_IDX_RATE 8'h4e
`define PFRC_IDX_CORE 8'h50
`define PFRC_IDX_STATUS 8'h51

// reset values
`define PFRC_RST_PULLDOWN 8'h00
`define PFRC_RST_DRIVE_A 8'h00
`define PFRC_RST_DRIVE_B 8'h00
`define PFRC_RST_RATE 8'h00
`define PFRC_RST_CORE 8'h00

// pull-down register fields
`define PFRC_BIT_BOOT_PD 4
`define PFRC_BIT_CCLK_PD 3
`define PFRC_BIT_CDAT_PD 2
`define PFRC_BIT_ADDR_PIN1_PULLDOWN_EN 1
`define PFRC_BIT_ADDR_PIN0_PULLDOWN_EN 0

// first drive register fields
`define PFRC_BIT_FRAME_DRV 4
`define PFRC_BIT_BITCLK_DRV 3
`define PFRC_BIT_CONV1_DRV 2
`define PFRC_BIT_CONV0_DRV 1

// second drive register fields
`define PFRC_BIT_CCLK_DRV 3
`define PFRC_BIT_CDAT_DRV 2

// rate register and core control fields
`define PFRC_RATE_MSB 2
`define PFRC_BIT_CORE_RUN 0
`define PFRC_CORE_SAMPLE_RATE_SEL_MSB 2
`define PFRC_CORE_SAMPLE_RATE_SEL_LSB 1
`define PFRC_CORE_SAMPLE_RATE_SEL_FAST 2'h3

// divide factors per code
`define PFRC_DIV_CODE0 5'h08
`define PFRC_DIV_CODE1 5'h09
`define PFRC_DIV_CODE2 5'h0a
`define PFRC_DIV_CODE3 5'h0c
`define PFRC_DIV_CODE4 5'h0e
`define PFRC_DIV_CODE5 5'h10

// bus responses
`define PFRC_RESP_OKAY 2'h0
`define PFRC_RESP_SLVERR 2'h2

`endif

// ### verilog/pfrc_pkg.sv
// types shared by the pad and fast rate control block
package pfrc_pkg;

  // register select decoded from an address
  typedef enum logic [2:0] {
    PFRC_SEL_NONE,
    PFRC_SEL_PD,
    PFRC_SEL_DRVA,
    PFRC_SEL_DRVB,
    PFRC_SEL_RATE,
    PFRC_SEL_CORE,
    PFRC_SEL_STAT
  } pfrc_sel_t;

  // pin controls driven to the pad ring
  typedef struct packed {
    logic boot_select_pulldown_en;
    logic ctrl_clock_pulldown_en;
    logic ctrl_data_pulldown_en;
    logic addr_pin1_pulldown_en;
    logic addr_pin0_pulldown_en;
    logic frame_clock_drive_sel;
    logic bit_clock_drive_sel;
    logic conv_out1_drive_sel;
    logic conv_out0_drive_sel;
    logic ctrl_clock_drive_sel;
    logic ctrl_data_drive_sel;
  } pfrc_pad_t;

  // software visible register contents
  typedef struct packed {
    logic [7:0] pin_pulldown_ctrl_b;
    logic [7:0] pin_drive_ctrl_a;
    logic [7:0] pin_drive_ctrl_b;
    logic [7:0] fast_rate_divider;
    logic [7:0] core_ctrl;
  } pfrc_regs_t;

  // whole state of the top module
  typedef struct packed {
    logic aw_held;
    logic w_held;
    pfrc_sel_t wsel;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    pfrc_regs_t regs;
    logic [2:0] applied;
  } pfrc_state_t;

  // whole state of the rate divider
  typedef struct packed {
    logic [4:0] count;
    logic pulse;
  } pfrc_div_state_t;

endpackage

// ### verilog/pfrc_rate_div.sv
// fast rate divider: counts master clock enables, emits one pulse per factor
`timescale 1ns/10ps
`include "pfrc_regs.svh"
module pfrc_rate_div
  import pfrc_pkg::*;
#(
  parameter int CNT_W = 5
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mclk_en,
  input wire logic enable,
  input wire logic [2:0] code,
  output logic fast_rate_en
);

  pfrc_div_state_t s;
  pfrc_div_state_t s_n;
  logic [CNT_W-1:0] factor;

  // code to division factor; unlisted codes fall back to divide by 8
  always_comb begin
    unique case (code)
      3'h0: factor = CNT_W'(`PFRC_DIV_CODE0);
      3'h1: factor = CNT_W'(`PFRC_DIV_CODE1);
      3'h2: factor = CNT_W'(`PFRC_DIV_CODE2);
      3'h3: factor = CNT_W'(`PFRC_DIV_CODE3);
      3'h4: factor = CNT_W'(`PFRC_DIV_CODE4);
      3'h5: factor = CNT_W'(`PFRC_DIV_CODE5);
      default: factor = CNT_W'(`PFRC_DIV_CODE0);
    endcase
  end

  // count enables, wrap at factor, gate on fast rate select
  always_comb begin
    s_n = s;
    s_n.pulse = 1'b0;
    if (!enable) begin
      s_n.count = '0;
    end else if (mclk_en) begin
      if (s.count >= factor - CNT_W'(1)) begin
        s_n.count = '0;
        s_n.pulse = 1'b1;
      end else begin
        s_n.count = s.count + CNT_W'(1);
      end
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= s_n;
    end
  end

  assign fast_rate_en = s.pulse;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // divider checks
  a_div_wrap_pulse: assert property (
    enable && mclk_en && s.count == factor - CNT_W'(1) && $stable(code) |=> fast_rate_en)
    else $error("divider did not pulse at terminal count");
  a_div_pulse_cause: assert property (
    fast_rate_en |-> $past(enable) && $past(mclk_en) && $past(s.count) >= $past(factor) - CNT_W'(1))
    else $error("divider pulsed away from terminal count");
  a_div_gate_off: assert property (
    !enable |=> !fast_rate_en ##1 !fast_rate_en or enable)
    else $error("divider pulsed while fast rate not selected");
  c_div_pulse: cover property (enable ##[1:200] fast_rate_en);

endmodule

// ### verilog/pfrc_top.sv
// pad pull-down, drive strength and fast rate registers behind AXI4-Lite
// Contract
// - an 8-bit pull-down register holds five enables in bits 4..0, 1 enables, reset 0.
// - the first drive register selects low or high drive in bits 4..1, reset 0.
// - the second drive register selects drive in bits 3 and 2, reset 0.
// - the 3-bit divider code divides the master clock only when the rate select is 11.
// - codes 000, 001, 010 divide by 8, 9, 10; the code resets to 000.
// - codes 011, 100, 101 divide by 12, 14, 16.
// - a new code takes effect only while core run is 0; a running core keeps the old one.
`timescale 1ns/10ps
`include "pfrc_regs.svh"
module pfrc_top
  import pfrc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mclk_en,
  output pfrc_pad_t pad_ctrl,
  output logic core_run,
  output logic [1:0] core_sample_rate_sel,
  output logic fast_rate_en
);

  pfrc_state_t s;
  pfrc_state_t s_n;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic have_aw;
  logic have_w;
  logic do_write;
  pfrc_sel_t cur_sel;
  logic [7:0] cur_data;
  logic cur_strb;
  logic [7:0] rd_mux;
  logic [1:0] rd_resp;
  logic fast_sel;

  // word address to register select
  function automatic pfrc_sel_t decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] idx;
    idx = a[ADDR_W-1:2];
    if (idx == (ADDR_W-2)'(`PFRC_IDX_PULLDOWN)) begin
      return PFRC_SEL_PD;
    end else if (idx == (ADDR_W-2)'(`PFRC_IDX_DRIVE_A)) begin
      return PFRC_SEL_DRVA;
    end else if (idx == (ADDR_W-2)'(`PFRC_IDX_DRIVE_B)) begin
      return PFRC_SEL_DRVB;
    end else if (idx == (ADDR_W-2)'(`PFRC_IDX_RATE)) begin
      return PFRC_SEL_RATE;
    end else if (idx == (ADDR_W-2)'(`PFRC_IDX_CORE)) begin
      return PFRC_SEL_CORE;
    end else if (idx == (ADDR_W-2)'(`PFRC_IDX_STATUS)) begin
      return PFRC_SEL_STAT;
    end
    return PFRC_SEL_NONE;
  endfunction

  // handshake readies; a channel stalls while its response is pending
  assign s_axi_awready = !s.aw_held && !s.bvalid;
  assign s_axi_wready = !s.w_held && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign ar_fire = s_axi_arvalid && s_axi_arready;

  // merge held and arriving halves of a write
  assign have_aw = s.aw_held || aw_fire;
  assign have_w = s.w_held || w_fire;
  assign do_write = have_aw && have_w && !s.bvalid;
  assign cur_sel = s.aw_held ? s.wsel : decode(s_axi_awaddr);
  assign cur_data = s.w_held ? s.wdata : s_axi_wdata[7:0];
  assign cur_strb = s.w_held ? s.wstrb0 : s_axi_wstrb[0];

  // read data mux; full bytes read back, reserved bits included
  always_comb begin
    rd_mux = 8'h00;
    rd_resp = `PFRC_RESP_OKAY;
    unique case (decode(s_axi_araddr))
      PFRC_SEL_PD: rd_mux = s.regs.pin_pulldown_ctrl_b;
      PFRC_SEL_DRVA: rd_mux = s.regs.pin_drive_ctrl_a;
      PFRC_SEL_DRVB: rd_mux = s.regs.pin_drive_ctrl_b;
      PFRC_SEL_RATE: rd_mux = s.regs.fast_rate_divider;
      PFRC_SEL_CORE: rd_mux = s.regs.core_ctrl;
      PFRC_SEL_STAT: rd_mux = {4'h0, fast_sel, s.applied};
      PFRC_SEL_NONE: rd_resp = `PFRC_RESP_SLVERR;
    endcase
  end

  // next state: bus channels, register writes, applied divider code
  always_comb begin
    s_n = s;
    if (s.bvalid && s_axi_bready) begin
      s_n.bvalid = 1'b0;
    end
    if (do_write) begin
      s_n.aw_held = 1'b0;
      s_n.w_held = 1'b0;
      s_n.bvalid = 1'b1;
      s_n.bresp = `PFRC_RESP_OKAY;
      unique case (cur_sel)
        PFRC_SEL_PD: begin
          if (cur_strb) s_n.regs.pin_pulldown_ctrl_b = cur_data;
        end
        PFRC_SEL_DRVA: begin
          if (cur_strb) s_n.regs.pin_drive_ctrl_a = cur_data;
        end
        PFRC_SEL_DRVB: begin
          if (cur_strb) s_n.regs.pin_drive_ctrl_b = cur_data;
        end
        PFRC_SEL_RATE: begin
          if (cur_strb) s_n.regs.fast_rate_divider = cur_data;
        end
        PFRC_SEL_CORE: begin
          if (cur_strb) s_n.regs.core_ctrl = cur_data;
        end
        PFRC_SEL_STAT: begin
          s_n.bresp = `PFRC_RESP_OKAY; // read-only, write dropped
        end
        PFRC_SEL_NONE: begin
          s_n.bresp = `PFRC_RESP_SLVERR;
        end
      endcase
    end else begin
      if (aw_fire) begin
        s_n.aw_held = 1'b1;
        s_n.wsel = decode(s_axi_awaddr);
      end
      if (w_fire) begin
        s_n.w_held = 1'b1;
        s_n.wdata = s_axi_wdata[7:0];
        s_n.wstrb0 = s_axi_wstrb[0];
      end
    end
    if (s.rvalid && s_axi_rready) begin
      s_n.rvalid = 1'b0;
    end
    if (ar_fire) begin
      s_n.rvalid = 1'b1;
      s_n.rdata = rd_mux;
      s_n.rresp = rd_resp;
    end
    // code passes to the divider only with the core stopped
    if (!core_run) begin
      s_n.applied = s.regs.fast_rate_divider[`PFRC_RATE_MSB:0];
    end
  end

  // state register, all reset values zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.regs.pin_pulldown_ctrl_b <= `PFRC_RST_PULLDOWN;
      s.regs.pin_drive_ctrl_a <= `PFRC_RST_DRIVE_A;
      s.regs.pin_drive_ctrl_b <= `PFRC_RST_DRIVE_B;
      s.regs.fast_rate_divider <= `PFRC_RST_RATE;
      s.regs.core_ctrl <= `PFRC_RST_CORE;
    end else begin
      s <= s_n;
    end
  end

  // bus outputs from flops, upper bits zero
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = {24'h00_0000, s.rdata};

  // core control fields
  assign core_run = s.regs.core_ctrl[`PFRC_BIT_CORE_RUN];
  assign core_sample_rate_sel = s.regs.core_ctrl[`PFRC_CORE_SAMPLE_RATE_SEL_MSB:`PFRC_CORE_SAMPLE_RATE_SEL_LSB];
  assign fast_sel = core_sample_rate_sel == `PFRC_CORE_SAMPLE_RATE_SEL_FAST;

  // pull-down enables, named bits only
  assign pad_ctrl.boot_select_pulldown_en = s.regs.pin_pulldown_ctrl_b[`PFRC_BIT_BOOT_PD];
  assign pad_ctrl.ctrl_clock_pulldown_en = s.regs.pin_pulldown_ctrl_b[`PFRC_BIT_CCLK_PD];
  assign pad_ctrl.ctrl_data_pulldown_en = s.regs.pin_pulldown_ctrl_b[`PFRC_BIT_CDAT_PD];
  assign pad_ctrl.addr_pin1_pulldown_en = s.regs.pin_pulldown_ctrl_b[`PFRC_BIT_ADDR_PIN1_PULLDOWN_EN];
  assign pad_ctrl.addr_pin0_pulldown_en = s.regs.pin_pulldown_ctrl_b[`PFRC_BIT_ADDR_PIN0_PULLDOWN_EN];

  // drive selects, reserved bits left unconnected
  assign pad_ctrl.frame_clock_drive_sel = s.regs.pin_drive_ctrl_a[`PFRC_BIT_FRAME_DRV];
  assign pad_ctrl.bit_clock_drive_sel = s.regs.pin_drive_ctrl_a[`PFRC_BIT_BITCLK_DRV];
  assign pad_ctrl.conv_out1_drive_sel = s.regs.pin_drive_ctrl_a[`PFRC_BIT_CONV1_DRV];
  assign pad_ctrl.conv_out0_drive_sel = s.regs.pin_drive_ctrl_a[`PFRC_BIT_CONV0_DRV];
  assign pad_ctrl.ctrl_clock_drive_sel = s.regs.pin_drive_ctrl_b[`PFRC_BIT_CCLK_DRV];
  assign pad_ctrl.ctrl_data_drive_sel = s.regs.pin_drive_ctrl_b[`PFRC_BIT_CDAT_DRV];

  // fast rate enable from the applied code
  pfrc_rate_div #(
    .CNT_W(5)
  ) u_rate_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .mclk_en(mclk_en),
    .enable(fast_sel),
    .code(s.applied),
    .fast_rate_en(fast_rate_en)
  );

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // register and pin checks
  a_pad_reset_zero: assert property (disable iff (1'b0)
    !aresetn |=> pad_ctrl == '0 && s.applied == 3'h0)
    else $error("pin controls not zero after reset");
  a_pd_write_map: assert property (
    do_write && cur_sel == PFRC_SEL_PD && cur_strb |=>
      pad_ctrl.boot_select_pulldown_en == $past(cur_data[4]) &&
      pad_ctrl.addr_pin0_pulldown_en == $past(cur_data[0]))
    else $error("pull-down write not reflected on pins");
  a_drva_write_map: assert property (
    do_write && cur_sel == PFRC_SEL_DRVA && cur_strb |=>
      pad_ctrl.frame_clock_drive_sel == $past(cur_data[4]) &&
      pad_ctrl.conv_out0_drive_sel == $past(cur_data[1]))
    else $error("first drive write not reflected on pins");
  a_drvb_write_map: assert property (
    do_write && cur_sel == PFRC_SEL_DRVB && cur_strb |=>
      pad_ctrl.ctrl_clock_drive_sel == $past(cur_data[3]) &&
      pad_ctrl.ctrl_data_drive_sel == $past(cur_data[2]))
    else $error("second drive write not reflected on pins");
  a_resv_kept_byte: assert property (
    do_write && cur_sel == PFRC_SEL_DRVA && cur_strb |=>
      s.regs.pin_drive_ctrl_a == $past(cur_data) ##1 $stable(pad_ctrl) or do_write)
    else $error("reserved bits not stored");
  a_rate_hold_run: assert property (
    core_run |=> $stable(s.applied))
    else $error("divider code changed while core runs");
  a_rate_apply_idle: assert property (
    !core_run |=> s.applied == $past(s.regs.fast_rate_divider[2:0]))
    else $error("divider code not applied while stopped");
  a_fast_gate_sel: assert property (
    !fast_sel ##1 !fast_sel |-> !fast_rate_en)
    else $error("fast rate pulse without fast select");
  a_bresp_timing: assert property (
    do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response not raised after write");

  // main scenarios
  c_write_pd: cover property (do_write && cur_sel == PFRC_SEL_PD);
  c_code_held: cover property (core_run && s.regs.fast_rate_divider[2:0] != s.applied);
  c_fast_pulse: cover property (fast_sel ##[1:100] fast_rate_en);
  c_read_back: cover property (ar_fire ##1 s_axi_rvalid && s_axi_rready);

endmodule

// ### tb/tb.sv
// self-checking bench for the pad and fast rate control block
`timescale 1ns/10ps
`include "pfrc_regs.svh"
module tb;
  import pfrc_pkg::*;
  localparam int LIMIT = 20000;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] awaddr = 12'h000;
  logic awvalid = 1'h0;
  logic awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'h0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'h0;
  logic [11:0] araddr = 12'h000;
  logic arvalid = 1'h0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'h0;
  logic mclk_en = 1'h0;
  logic [1:0] mdiv = 2'h0;
  pfrc_pad_t pad_ctrl;
  logic core_run;
  logic [1:0] core_sample_rate_sel;
  logic fast_rate_en;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int g;
  int fac [6] = '{8, 9, 10, 12, 14, 16};
  logic [7:0] t_idx [6] = '{`PFRC_IDX_PULLDOWN, `PFRC_IDX_PULLDOWN, `PFRC_IDX_DRIVE_A,
                           `PFRC_IDX_DRIVE_A, `PFRC_IDX_DRIVE_B, `PFRC_IDX_DRIVE_B};
  logic [7:0] t_dat [6] = '{8'h15, 8'he0, 8'h14, 8'he1, 8'h08, 8'hf7};
  logic [10:0] t_pad [6] = '{11'h540, 11'h000, 11'h028, 11'h000, 11'h002, 11'h001};

  pfrc_top #(.ADDR_W(12)) i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .mclk_en(mclk_en), .pad_ctrl(pad_ctrl), .core_run(core_run),
    .core_sample_rate_sel(core_sample_rate_sel), .fast_rate_en(fast_rate_en));

  // 25 MHz clock
  initial begin
    forever #20 aclk = ~aclk;
  end

  // master clock enable, one pulse every fourth cycle
  always @(posedge aclk) begin
    mdiv <= mdiv + 2'h1;
    mclk_en <= (mdiv == 2'h3);
  end

  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // byte address of a register index
  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'h1;
    w = 1'h1;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && awready === 1'h1) begin
        aw = 1'h0;
        awvalid <= 1'h0;
      end
      if (w && wready === 1'h1) begin
        w = 1'h0;
        wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    // one idle edge so the next call never drives bready twice in a step
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk("rdata", {24'h00_0000, exp}, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    // one idle edge so the next call never drives rready twice in a step
    @(posedge aclk);
  endtask

  // cycles between two fast rate pulses, after settling
  task automatic gap(output int n);
    repeat (3) begin
      n = 0;
      do begin
        @(posedge aclk);
        n++;
      end while (fast_rate_en !== 1'h1 && n < 300);
    end
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    // reset values
    rd(ba(`PFRC_IDX_PULLDOWN), 8'h00, 2'h0);
    rd(ba(`PFRC_IDX_DRIVE_A), 8'h00, 2'h0);
    rd(ba(`PFRC_IDX_DRIVE_B), 8'h00, 2'h0);
    rd(ba(`PFRC_IDX_RATE), 8'h00, 2'h0);
    chk("pad_ctrl", 32'h0000_0000, {21'h0, pad_ctrl});
    // pin bits reach the pads, reserved bits read back and steer nothing
    for (int i = 0; i < 6; i++) begin
      wr(ba(t_idx[i]), t_dat[i], 4'hf, 2'h0);
      chk("pad_ctrl", {21'h0, t_pad[i]}, {21'h0, pad_ctrl});
      rd(ba(t_idx[i]), t_dat[i], 2'h0);
    end
    // masked byte is not stored
    wr(ba(`PFRC_IDX_PULLDOWN), 8'h1f, 4'h0, 2'h0);
    rd(ba(`PFRC_IDX_PULLDOWN), 8'he0, 2'h0);
    // unmapped place
    wr(12'h000, 8'h5a, 4'hf, 2'h2);
    rd(12'h000, 8'h00, 2'h2);
    // divider codes 0 to 5 with the fast select on and the core stopped
    wr(ba(`PFRC_IDX_CORE), 8'h06, 4'hf, 2'h0);
    for (int c = 0; c < 6; c++) begin
      wr(ba(`PFRC_IDX_RATE), c[7:0], 4'hf, 2'h0);
      gap(g);
      chk("pulse gap", 4 * fac[c], g);
    end
    // a running core keeps the applied code
    wr(ba(`PFRC_IDX_RATE), 8'h00, 4'hf, 2'h0);
    wr(ba(`PFRC_IDX_CORE), 8'h07, 4'hf, 2'h0);
    chk("core_run", 32'h0000_0001, {31'h0, core_run});
    chk("core_sample_rate_sel", 32'h0000_0003, {30'h0, core_sample_rate_sel});
    wr(ba(`PFRC_IDX_RATE), 8'h05, 4'hf, 2'h0);
    gap(g);
    chk("pulse gap", 32'h0000_0020, g);
    rd(ba(`PFRC_IDX_STATUS), 8'h08, 2'h0);
    rd(ba(`PFRC_IDX_RATE), 8'h05, 2'h0);
    wr(ba(`PFRC_IDX_CORE), 8'h06, 4'hf, 2'h0);
    gap(g);
    chk("pulse gap", 32'h0000_0040, g);
    rd(ba(`PFRC_IDX_STATUS), 8'h0d, 2'h0);
    // rate select 10 stops the pulses
    wr(ba(`PFRC_IDX_CORE), 8'h04, 4'hf, 2'h0);
    g = 0;
    repeat (200) begin
      @(posedge aclk);
      if (fast_rate_en === 1'h1) g++;
    end
    chk("pulse count", 32'h0000_0000, g);
    finish_test();
  end
endmodule
